// file: src/mvfd_pkg.sv
// Package of constants and types for the masked vector FMA datapath
package mvfd_pkg;
  localparam int VEC_W = 512;
  localparam int LANE_W = 128;
  localparam int ELEM_W = 32;
  localparam int N_LANES = VEC_W / LANE_W;
  localparam int ELEMS_PER_LANE = LANE_W / ELEM_W;
  localparam int N_ELEMS = VEC_W / ELEM_W;
  localparam int N_MASKS = 8;
  localparam int MSEL_W = 3;
  localparam int ELEM_BYTES = ELEM_W / 8;
  localparam int GROUP_SIZE = 4;
  localparam int GROUP_SCALE_IDX = 1;
  localparam int GROUP_BIAS_IDX = 0;
  localparam logic [MSEL_W-1:0] DEFAULT_MASK_SEL = 3'h0;
  localparam logic [N_ELEMS-1:0] ALL_ONES_MASK = 16'hFFFF;
  localparam logic [N_ELEMS-1:0] MASK_RESET = 16'h0000;
  localparam logic [VEC_W-1:0] VEC_RESET = '0;
  localparam int PIPE_LAT = 1;

  typedef enum logic [3:0] {
    MVFD_OP_NOP,
    MVFD_OP_ADD,
    MVFD_OP_MUL,
    MVFD_OP_FMA_A,
    MVFD_OP_FMA_B,
    MVFD_OP_FMA_C,
    MVFD_OP_SCALE_BIAS,
    MVFD_OP_ADC,
    MVFD_OP_SBB,
    MVFD_OP_KAND,
    MVFD_OP_KOR,
    MVFD_OP_KXOR,
    MVFD_OP_KMOV_FROM_GPR
  } mvfd_op_e;
endpackage

// file: src/mvfd_datapath.sv
// Masked 16-element vector datapath with FMA variants, carry chain and mask registers
`timescale 1ns/1ps
// ----------------------------------------------------------------
// How it works
// RL1 - Memory data, swizzle and broadcast feed only the second source operand.
// RL2 - Fused variant picks the expression position that gets the modified source.
// RL3 - Scale-and-bias: each group of four is u times v[base+1] plus v[base].
// RL4 - Carry ops take a per-element carry-in mask and write a carry-out mask.
// RL5 - A 512-bit vector is four 128-bit lanes, lane zero at the low end.
// RL6 - Each lane has four 32-bit elements; sixteen elements indexed upward.
// RL7 - Memory load: lowest address to element zero, four bytes per element.
// RL8 - Mask registers only see AND, OR, XOR, moves from general registers and carry-outs.
// RL9 - Unmasked operations overwrite every destination element.
// RL10 - Masked operations update only elements whose mask bit is one.
// RL11 - Elements with a zero mask bit keep their old contents.
// RL12 - No mask given means an all-ones sixteen-bit mask.
// RL13 - Write-mask selector zero means no mask, never mask register zero's contents.
// RL14 - Mask register zero still serves as carry source, carry target and result.
// RL15 - FMA orders 132, 213 and 231 choose which operands multiply and add.
// RL16 - Mask registers are sixteen bits, bit i governing element i.
// ----------------------------------------------------------------
module mvfd_datapath #(
  parameter int NUM_MASKS = mvfd_pkg::N_MASKS
) (
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic issue_i,
  input wire mvfd_pkg::mvfd_op_e op_i,
  input wire logic [mvfd_pkg::VEC_W-1:0] dest_vector_i,
  input wire logic [mvfd_pkg::VEC_W-1:0] first_src_vector_i,
  input wire logic [mvfd_pkg::VEC_W-1:0] second_src_vector_i,
  input wire logic [mvfd_pkg::VEC_W-1:0] mem_data_i,
  input wire logic use_mem_i,
  input wire logic [mvfd_pkg::VEC_W-1:0] modified_src_i,
  input wire logic use_modified_i,
  input wire logic [mvfd_pkg::MSEL_W-1:0] wmask_sel_i,
  input wire logic [mvfd_pkg::MSEL_W-1:0] carry_in_sel_i,
  input wire logic [mvfd_pkg::MSEL_W-1:0] mask_dst_sel_i,
  input wire logic [mvfd_pkg::MSEL_W-1:0] mask_src_a_sel_i,
  input wire logic [mvfd_pkg::MSEL_W-1:0] mask_src_b_sel_i,
  input wire logic [mvfd_pkg::N_ELEMS-1:0] gpr_mask_i,
  input wire logic [mvfd_pkg::MSEL_W-1:0] mask_rd_sel_i,
  output logic [mvfd_pkg::N_ELEMS-1:0] mask_rd_o,
  output logic result_valid_o,
  output logic [mvfd_pkg::VEC_W-1:0] result_o,
  output logic [mvfd_pkg::N_ELEMS-1:0] result_wmask_o
);
  import mvfd_pkg::*;

  // ----------------------------------------------------------------
  // Operand selection
  // ----------------------------------------------------------------
  logic [VEC_W-1:0] src2;
  logic [N_ELEMS-1:0] mask_r [NUM_MASKS];
  logic [N_ELEMS-1:0] wmask;
  logic [N_ELEMS-1:0] carry_in;
  logic [N_ELEMS-1:0] carry_out;
  logic [VEC_W-1:0] op_res;
  logic is_vec_op;
  logic is_carry_op;
  logic is_mask_op;
  logic [N_ELEMS-1:0] mask_res;

  // Memory data and modifiers only replace the second source
  always_comb begin
    src2 = second_src_vector_i; // RL1
    if (use_mem_i) begin
      src2 = mem_data_i; // RL1
    end else if (use_modified_i) begin
      src2 = modified_src_i; // RL1
    end
  end

  // Selector zero is the no-mask encoding
  assign wmask = (wmask_sel_i == DEFAULT_MASK_SEL) ? ALL_ONES_MASK : // RL12 RL13
                 mask_r[wmask_sel_i]; // RL16
  // Mask register zero may supply a carry
  assign carry_in = mask_r[carry_in_sel_i]; // RL14 RL4

  // ----------------------------------------------------------------
  // Per-element arithmetic
  // ----------------------------------------------------------------
  // Element e sits at bits e*32 of the vector, lane e/4 at bits lane*128
  genvar e;
  generate
    for (e = 0; e < N_ELEMS; e++) begin : g_elem
      localparam int BASE = (e / GROUP_SIZE) * GROUP_SIZE;
      logic [ELEM_W-1:0] d;
      logic [ELEM_W-1:0] a;
      logic [ELEM_W-1:0] b;
      logic [ELEM_W-1:0] sc;
      logic [ELEM_W-1:0] bi;
      logic [ELEM_W:0] wide;
      logic [ELEM_W-1:0] r;
      logic co;
      assign d = dest_vector_i[e*ELEM_W +: ELEM_W]; // RL5 RL6
      assign a = first_src_vector_i[e*ELEM_W +: ELEM_W]; // RL6
      assign b = src2[e*ELEM_W +: ELEM_W]; // RL6 RL7
      assign sc = src2[(BASE + GROUP_SCALE_IDX)*ELEM_W +: ELEM_W]; // RL3
      assign bi = src2[(BASE + GROUP_BIAS_IDX)*ELEM_W +: ELEM_W]; // RL3
      always_comb begin
        wide = '0;
        r = '0;
        co = 1'h0;
        unique case (op_i)
          MVFD_OP_ADD: r = a + b;
          MVFD_OP_MUL: r = ELEM_W'(a * b);
          MVFD_OP_FMA_A: r = ELEM_W'(d * b + a); // RL15 RL2
          MVFD_OP_FMA_B: r = ELEM_W'(a * d + b); // RL15 RL2
          MVFD_OP_FMA_C: r = ELEM_W'(a * b + d); // RL15 RL2
          MVFD_OP_SCALE_BIAS: r = ELEM_W'(a * sc + bi); // RL3
          MVFD_OP_ADC: begin
            wide = {1'h0, a} + {1'h0, b} + {{ELEM_W{1'h0}}, carry_in[e]}; // RL4
            r = wide[ELEM_W-1:0];
            co = wide[ELEM_W]; // RL4
          end
          MVFD_OP_SBB: begin
            wide = {1'h0, a} - {1'h0, b} - {{ELEM_W{1'h0}}, carry_in[e]}; // RL4
            r = wide[ELEM_W-1:0];
            co = wide[ELEM_W]; // RL4
          end
          default: r = d;
        endcase
      end
      // Masked-off elements keep the old destination
      assign op_res[e*ELEM_W +: ELEM_W] = wmask[e] ? r : d; // RL9 RL10 RL11
      assign carry_out[e] = co;
    end
  endgenerate

  assign is_carry_op = (op_i == MVFD_OP_ADC) || (op_i == MVFD_OP_SBB);
  assign is_vec_op = (op_i != MVFD_OP_NOP) && !is_mask_op;
  assign is_mask_op = (op_i == MVFD_OP_KAND) || (op_i == MVFD_OP_KOR) ||
                      (op_i == MVFD_OP_KXOR) || (op_i == MVFD_OP_KMOV_FROM_GPR);

  // Mask operations offer logic operations and moves only
  always_comb begin
    mask_res = mask_r[mask_src_a_sel_i];
    unique case (op_i)
      MVFD_OP_KAND: mask_res = mask_r[mask_src_a_sel_i] & mask_r[mask_src_b_sel_i]; // RL8
      MVFD_OP_KOR: mask_res = mask_r[mask_src_a_sel_i] | mask_r[mask_src_b_sel_i]; // RL8
      MVFD_OP_KXOR: mask_res = mask_r[mask_src_a_sel_i] ^ mask_r[mask_src_b_sel_i]; // RL8
      MVFD_OP_KMOV_FROM_GPR: mask_res = gpr_mask_i; // RL8
      default: mask_res = mask_r[mask_src_a_sel_i];
    endcase
  end

  // ----------------------------------------------------------------
  // Mask register file
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      for (int i = 0; i < NUM_MASKS; i++) begin
        mask_r[i] <= MASK_RESET;
      end
    end else if (issue_i && is_carry_op) begin
      mask_r[mask_dst_sel_i] <= carry_out; // RL4 RL14
    end else if (issue_i && is_mask_op) begin
      mask_r[mask_dst_sel_i] <= mask_res; // RL8
    end
  end

  assign mask_rd_o = mask_r[mask_rd_sel_i];

  // ----------------------------------------------------------------
  // Result register
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      result_valid_o <= 1'h0;
      result_o <= VEC_RESET;
      result_wmask_o <= MASK_RESET;
    end else begin
      result_valid_o <= issue_i && is_vec_op;
      if (issue_i && is_vec_op) begin
        result_o <= op_res; // RL9 RL10 RL11
        result_wmask_o <= wmask; // RL12
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_default_mask_ones: assert property ( // RL13
    @(posedge core_clk_i) disable iff (srst_i)
    (issue_i && is_vec_op && wmask_sel_i == DEFAULT_MASK_SEL) |=>
      result_wmask_o == ALL_ONES_MASK)
    else $error("selector zero did not give an all-ones mask");
  a_unmasked_full_write: assert property ( // RL9
    @(posedge core_clk_i) disable iff (srst_i)
    (issue_i && op_i == MVFD_OP_ADD && wmask_sel_i == DEFAULT_MASK_SEL) |=>
      result_o[ELEM_W-1:0] == ELEM_W'($past(first_src_vector_i[ELEM_W-1:0]) +
                                      $past(src2[ELEM_W-1:0])))
    else $error("unmasked add did not overwrite element zero");
  a_masked_keep_old: assert property ( // RL11
    @(posedge core_clk_i) disable iff (srst_i)
    (issue_i && is_vec_op && !wmask[N_ELEMS-1]) |=>
      result_o[VEC_W-1 -: ELEM_W] == $past(dest_vector_i[VEC_W-1 -: ELEM_W]))
    else $error("masked-off top element was changed");
  a_masked_update_set: assert property ( // RL10
    @(posedge core_clk_i) disable iff (srst_i)
    (issue_i && op_i == MVFD_OP_ADD && wmask[1]) |=>
      result_o[ELEM_W +: ELEM_W] == ELEM_W'($past(first_src_vector_i[ELEM_W +: ELEM_W]) +
                                           $past(src2[ELEM_W +: ELEM_W])))
    else $error("enabled element one not updated");
  a_scale_bias_group: assert property ( // RL3
    @(posedge core_clk_i) disable iff (srst_i)
    (issue_i && op_i == MVFD_OP_SCALE_BIAS && wmask[6]) |=>
      result_o[6*ELEM_W +: ELEM_W] ==
        ELEM_W'($past(first_src_vector_i[6*ELEM_W +: ELEM_W]) *
                $past(src2[5*ELEM_W +: ELEM_W]) + $past(src2[4*ELEM_W +: ELEM_W])))
    else $error("scale-and-bias element six wrong");
  a_scale_bias_top: assert property ( // RL3 RL5
    @(posedge core_clk_i) disable iff (srst_i)
    (issue_i && op_i == MVFD_OP_SCALE_BIAS && wmask[15]) |=>
      result_o[15*ELEM_W +: ELEM_W] ==
        ELEM_W'($past(first_src_vector_i[15*ELEM_W +: ELEM_W]) *
                $past(src2[13*ELEM_W +: ELEM_W]) + $past(src2[12*ELEM_W +: ELEM_W])))
    else $error("scale-and-bias element fifteen wrong");
  a_fma_order_a: assert property ( // RL15 RL2
    @(posedge core_clk_i) disable iff (srst_i)
    (issue_i && op_i == MVFD_OP_FMA_A && wmask[2]) |=>
      result_o[2*ELEM_W +: ELEM_W] == ELEM_W'($past(dest_vector_i[2*ELEM_W +: ELEM_W]) *
        $past(src2[2*ELEM_W +: ELEM_W]) + $past(first_src_vector_i[2*ELEM_W +: ELEM_W])))
    else $error("order 132 result wrong");
  a_fma_order_b: assert property ( // RL15 RL2
    @(posedge core_clk_i) disable iff (srst_i)
    (issue_i && op_i == MVFD_OP_FMA_B && wmask[3]) |=>
      result_o[3*ELEM_W +: ELEM_W] == ELEM_W'($past(first_src_vector_i[3*ELEM_W +: ELEM_W]) *
        $past(dest_vector_i[3*ELEM_W +: ELEM_W]) + $past(src2[3*ELEM_W +: ELEM_W])))
    else $error("order 213 result wrong");
  a_fma_order_c: assert property ( // RL15
    @(posedge core_clk_i) disable iff (srst_i)
    (issue_i && op_i == MVFD_OP_FMA_C && wmask[0]) |=>
      result_o[ELEM_W-1:0] == ELEM_W'($past(first_src_vector_i[ELEM_W-1:0]) *
        $past(src2[ELEM_W-1:0]) + $past(dest_vector_i[ELEM_W-1:0])))
    else $error("order 231 result wrong");
  a_mem_second_src: assert property ( // RL1
    @(posedge core_clk_i) disable iff (srst_i)
    use_mem_i |-> src2 == mem_data_i)
    else $error("memory data not routed to second source");
  a_mod_second_src: assert property ( // RL1
    @(posedge core_clk_i) disable iff (srst_i)
    (!use_mem_i && use_modified_i) |-> src2 == modified_src_i)
    else $error("modified copy not routed to second source");
  a_reg_second_src: assert property ( // RL1
    @(posedge core_clk_i) disable iff (srst_i)
    (!use_mem_i && !use_modified_i) |-> src2 == second_src_vector_i)
    else $error("second source register not used");
  a_mem_elem_order: assert property ( // RL7
    @(posedge core_clk_i) disable iff (srst_i)
    (issue_i && op_i == MVFD_OP_ADD && use_mem_i && wmask[N_ELEMS-1]) |=>
      result_o[VEC_W-1 -: ELEM_W] == ELEM_W'($past(first_src_vector_i[VEC_W-1 -: ELEM_W]) +
        $past(mem_data_i[(N_ELEMS-1)*ELEM_BYTES*8 +: ELEM_W])))
    else $error("highest memory element not in element fifteen");
  a_lane_keep_old: assert property ( // RL5 RL11
    @(posedge core_clk_i) disable iff (srst_i)
    (issue_i && is_vec_op && !wmask[ELEMS_PER_LANE]) |=>
      result_o[LANE_W +: ELEM_W] == $past(dest_vector_i[LANE_W +: ELEM_W]))
    else $error("masked-off first element of lane one was changed");
  a_wmask_from_reg: assert property ( // RL10 RL16
    @(posedge core_clk_i) disable iff (srst_i)
    (issue_i && is_vec_op && wmask_sel_i != DEFAULT_MASK_SEL) |=>
      result_wmask_o == $past(mask_r[wmask_sel_i]))
    else $error("write mask not taken from the selected register");
  a_vec_valid_pulse: assert property ( // RL9
    @(posedge core_clk_i) disable iff (srst_i)
    (issue_i && is_vec_op) |=> result_valid_o)
    else $error("vector operation gave no result strobe");
  a_no_result_valid: assert property ( // RL8
    @(posedge core_clk_i) disable iff (srst_i)
    !(issue_i && is_vec_op) |=> !result_valid_o)
    else $error("result strobe without a vector operation");
  a_result_holds: assert property ( // RL9
    @(posedge core_clk_i) disable iff (srst_i)
    !(issue_i && is_vec_op) |=>
      ($stable(result_o) && $stable(result_wmask_o)))
    else $error("result changed without a vector operation");
  a_adc_carry_elem: assert property ( // RL4
    @(posedge core_clk_i) disable iff (srst_i)
    (issue_i && op_i == MVFD_OP_ADC && wmask[3]) |=>
      {mask_r[$past(mask_dst_sel_i)][3], result_o[3*ELEM_W +: ELEM_W]} ==
        ({1'h0, $past(first_src_vector_i[3*ELEM_W +: ELEM_W])} +
         {1'h0, $past(src2[3*ELEM_W +: ELEM_W])} +
         {{ELEM_W{1'h0}}, $past(carry_in[3])}))
    else $error("carry-add element three or its carry-out wrong");
  a_sbb_borrow_elem: assert property ( // RL4
    @(posedge core_clk_i) disable iff (srst_i)
    (issue_i && op_i == MVFD_OP_SBB && wmask[9]) |=>
      {mask_r[$past(mask_dst_sel_i)][9], result_o[9*ELEM_W +: ELEM_W]} ==
        ({1'h0, $past(first_src_vector_i[9*ELEM_W +: ELEM_W])} -
         {1'h0, $past(src2[9*ELEM_W +: ELEM_W])} -
         {{ELEM_W{1'h0}}, $past(carry_in[9])}))
    else $error("borrow-subtract element nine or its borrow wrong");
  a_carry_to_mask: assert property ( // RL4
    @(posedge core_clk_i) disable iff (srst_i)
    (issue_i && is_carry_op) ##1 (mask_rd_sel_i == $past(mask_dst_sel_i)) |->
      mask_rd_o == $past(carry_out))
    else $error("carry-out not captured in mask register");
  a_carry_into_zero: assert property ( // RL14
    @(posedge core_clk_i) disable iff (srst_i)
    (issue_i && is_carry_op && mask_dst_sel_i == '0) |=>
      mask_r[0] == $past(carry_out))
    else $error("carry-out not written to mask register zero");
  a_mask_xor_only: assert property ( // RL8
    @(posedge core_clk_i) disable iff (srst_i)
    (issue_i && op_i == MVFD_OP_KXOR) ##1 (mask_rd_sel_i == $past(mask_dst_sel_i)) |->
      mask_rd_o == ($past(mask_r[mask_src_a_sel_i]) ^ $past(mask_r[mask_src_b_sel_i])))
    else $error("mask xor result wrong");
  a_mask_and_only: assert property ( // RL8
    @(posedge core_clk_i) disable iff (srst_i)
    (issue_i && op_i == MVFD_OP_KAND) |=>
      mask_r[$past(mask_dst_sel_i)] ==
        ($past(mask_r[mask_src_a_sel_i]) & $past(mask_r[mask_src_b_sel_i])))
    else $error("mask and result wrong");
  a_mask_gpr_move: assert property ( // RL8
    @(posedge core_clk_i) disable iff (srst_i)
    (issue_i && op_i == MVFD_OP_KMOV_FROM_GPR) |=>
      mask_r[$past(mask_dst_sel_i)] == $past(gpr_mask_i))
    else $error("move from general register wrong");
  a_mask_untouched: assert property ( // RL8
    @(posedge core_clk_i) disable iff (srst_i)
    !(issue_i && (is_carry_op || is_mask_op)) |=>
      mask_r[$past(mask_dst_sel_i)] == $past(mask_r[mask_dst_sel_i]))
    else $error("mask register changed without a mask or carry operation");

endmodule

// file: verification/masked_vector_fma_datapath_tb.sv
// Self-checking testbench for the masked vector FMA datapath
`timescale 1ns/1ps
module masked_vector_fma_datapath_tb;
  import mvfd_pkg::*;
  // ------------------------------------------------------------
  // Stimulus, outputs and model state
  // ------------------------------------------------------------
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic issue_i = 1'b0;
  mvfd_op_e op_i = MVFD_OP_NOP;
  logic [VEC_W-1:0] dv = '0, av = '0, bv = '0, mv = '0, xv = '0, res;
  logic um = 1'b0, ux = 1'b0, vld;
  logic [2:0] ws = '0, cs = '0, ds = '0, sa = '0, sb = '0, rsel = '0;
  logic [15:0] gpr = '0, mask_rd, rwm;
  logic [15:0] km [8];
  logic [31:0] seed = 32'hA74E;
  int miscompares = 0;
  int cmp_count = 0;

  always #4 core_clk_i = ~core_clk_i;

  mvfd_datapath dut (.core_clk_i(core_clk_i), .srst_i(srst_i), .issue_i(issue_i), .op_i(op_i),
    .dest_vector_i(dv), .first_src_vector_i(av), .second_src_vector_i(bv), .mem_data_i(mv),
    .use_mem_i(um), .modified_src_i(xv), .use_modified_i(ux), .wmask_sel_i(ws),
    .carry_in_sel_i(cs), .mask_dst_sel_i(ds), .mask_src_a_sel_i(sa), .mask_src_b_sel_i(sb),
    .gpr_mask_i(gpr), .mask_rd_sel_i(rsel), .mask_rd_o(mask_rd), .result_valid_o(vld),
    .result_o(res), .result_wmask_o(rwm));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [VEC_W-1:0] rv();
    logic [VEC_W-1:0] v;
    for (int i = 0; i < N_ELEMS; i++) v[i*32+:32] = rnd();
    return v;
  endfunction

  task automatic chk(input logic [VEC_W-1:0] got, input logic [VEC_W-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Mask register operation, result read back next cycle
  task automatic mop(input mvfd_op_e op, input logic [2:0] d, input logic [2:0] a,
                     input logic [2:0] b);
    logic [15:0] g;
    g = 16'(rnd());
    @(posedge core_clk_i);
    issue_i <= 1'b1;
    op_i <= op;
    ds <= d;
    sa <= a;
    sb <= b;
    gpr <= g;
    rsel <= d;
    case (op)
      MVFD_OP_KAND: km[d] = km[a] & km[b];
      MVFD_OP_KOR: km[d] = km[a] | km[b];
      MVFD_OP_KXOR: km[d] = km[a] ^ km[b];
      default: km[d] = g;
    endcase
    @(posedge core_clk_i);
    issue_i <= 1'b0;
    #1;
    chk(mask_rd, km[d]);
    chk(vld, 0);
  endtask

  // Vector operation with random operands, compared with the model
  task automatic vop(input mvfd_op_e op, input logic [2:0] w, input logic [2:0] c,
                     input logic [2:0] d);
    logic [VEC_W-1:0] an, bn, dn, mn, xn, b, exp;
    logic [31:0] r, a, bb, de;
    logic [32:0] t;
    logic [15:0] wm, co;
    int g;
    an = rv();
    bn = rv();
    dn = rv();
    mn = rv();
    xn = rv();
    r = rnd();
    b = r[0] ? mn : (r[1] ? xn : bn);
    wm = (w == 3'h0) ? ALL_ONES_MASK : km[w];
    for (int e = 0; e < N_ELEMS; e++) begin
      a = an[e*32+:32];
      bb = b[e*32+:32];
      de = dn[e*32+:32];
      g = (e / GROUP_SIZE) * GROUP_SIZE;
      case (op)
        MVFD_OP_ADD: t = a + bb;
        MVFD_OP_MUL: t = a * bb;
        MVFD_OP_FMA_A: t = de * bb + a;
        MVFD_OP_FMA_B: t = a * de + bb;
        MVFD_OP_FMA_C: t = a * bb + de;
        MVFD_OP_SCALE_BIAS: t = a * b[(g+1)*32+:32] + b[g*32+:32];
        MVFD_OP_ADC: t = a + bb + km[c][e];
        default: t = a - bb - km[c][e];
      endcase
      exp[e*32+:32] = wm[e] ? t[31:0] : de;
      co[e] = t[32];
    end
    @(posedge core_clk_i);
    issue_i <= 1'b1;
    op_i <= op;
    av <= an;
    bv <= bn;
    dv <= dn;
    mv <= mn;
    xv <= xn;
    um <= r[0];
    ux <= r[1];
    ws <= w;
    cs <= c;
    ds <= d;
    rsel <= d;
    if (op == MVFD_OP_ADC || op == MVFD_OP_SBB) km[d] = co;
    @(posedge core_clk_i);
    issue_i <= 1'b0;
    #1;
    chk(vld, 1'h1);
    chk(res, exp);
    chk(rwm, wm);
    chk(mask_rd, km[d]);
    @(posedge core_clk_i);
    #1;
    chk(vld, 1'h0);
  endtask

  // ------------------------------------------------------------
  // Main sequence and watchdog
  // ------------------------------------------------------------
  initial begin
    mvfd_op_e op;
    logic [31:0] r;
    repeat (12) @(posedge core_clk_i);
    srst_i <= 1'b0;
    for (int k = 0; k < N_MASKS; k++) begin
      @(posedge core_clk_i);
      rsel <= 3'(k);
      #1;
      chk(mask_rd, MASK_RESET);
      chk(res, VEC_RESET);
      chk(rwm, MASK_RESET);
      chk(vld, 1'h0);
    end
    for (int k = 0; k < N_MASKS; k++) mop(MVFD_OP_KMOV_FROM_GPR, 3'(k), 3'h0, 3'h0);
    for (int k = 0; k < 12; k++) begin
      r = rnd();
      mop(mvfd_op_e'(9 + k % 3), r[2:0], r[5:3], r[8:6]);
    end
    @(posedge core_clk_i);
    issue_i <= 1'b1;
    op_i <= MVFD_OP_NOP;
    @(posedge core_clk_i);
    issue_i <= 1'b0;
    #1;
    chk(vld, 1'h0);
    chk(res, VEC_RESET);
    chk(rwm, MASK_RESET);
    vop(MVFD_OP_ADD, 3'h0, 3'h0, 3'h0);
    vop(MVFD_OP_ADC, 3'h0, 3'h0, 3'h0);
    for (int k = 0; k < 96; k++) begin
      r = rnd();
      op = mvfd_op_e'(1 + k % 8);
      if (op == MVFD_OP_ADC || op == MVFD_OP_SBB) vop(op, 3'h0, r[5:3], r[8:6]);
      else vop(op, r[2:0], r[5:3], r[8:6]);
      if (k % 8 == 7) mop(MVFD_OP_KMOV_FROM_GPR, r[11:9], 3'h0, 3'h0);
    end
    end_of_test();
  end

  initial begin
    #20000;
    miscompares++;
    end_of_test();
  end
endmodule
